// *** pktr_pkg.sv ***
// shared constants and types for the peak tracking serial slave
package pktr_pkg;

    // ------------------------------------------------------------
    // register pointers
    // ------------------------------------------------------------
    localparam logic [7:0]  PTR_RUNNING_MINIMUM = 8'h06;
    localparam logic [7:0]  PTR_RUNNING_MAXIMUM = 8'h07;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [15:0] RST_RUNNING_MINIMUM = 16'h0FFF;
    localparam logic [15:0] RST_RUNNING_MAXIMUM = 16'h0000;
    localparam int          PEAK_MSB            = 11;
    localparam int          PEAK_LSB            = 2;
    localparam logic [15:0] PEAK_FIELD_MASK     = 16'h0FFC;
    localparam logic [15:0] READ_UNMAPPED       = 16'h0000;

    // ------------------------------------------------------------
    // serial protocol constants
    // ------------------------------------------------------------
    localparam logic [6:0]  SLAVE_ADDR_DEFAULT  = 7'h54;
    localparam logic [4:0]  HS_MASTER_CODE      = 5'h01;
    localparam logic [3:0]  BYTE_BITS           = 4'h8;
    localparam logic [3:0]  LAST_TX_BIT         = 4'h7;
    localparam logic [1:0]  BYTE_POINTER        = 2'h0;
    localparam logic [1:0]  BYTE_UPPER          = 2'h1;
    localparam logic [1:0]  BYTE_LOWER          = 2'h2;

    // ------------------------------------------------------------
    // timing: glitch filter on the link clock
    // ------------------------------------------------------------
    localparam int          LINK_PERIOD_PS      = 15000;
    localparam int          SPIKE_REJECT_PS     = 30000;
    localparam int          FILT_CYC            = (SPIKE_REJECT_PS + LINK_PERIOD_PS - 1)
                                                  / LINK_PERIOD_PS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PKTR_IDLE,
        PKTR_ADDR,
        PKTR_ADDR_ACK,
        PKTR_RX,
        PKTR_RX_ACK,
        PKTR_TX,
        PKTR_TX_ACK
    } pktr_state_t;

    typedef struct packed {
        logic [7:0]  ptr;
        logic [15:0] data;
    } pktr_wr_t;

    typedef struct packed {
        logic [15:0] minimum;
        logic [15:0] maximum;
    } pktr_peak_t;

endpackage : pktr_pkg

// *** pktr_sync.sv ***
// two flip-flop synchroniser for a group of single-bit levels
`timescale 1ns/1ps
`default_nettype none

module pktr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------
    // two stages, the first one read by the second only
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk) begin
        meta     <= async_in;
        sync_out <= meta;
    end

endmodule // pktr_sync

`default_nettype wire

// *** pktr_top.sv ***
// serial slave port with running minimum and maximum peak registers
`timescale 1ns/1ps
`default_nettype none

// How it works
// - minimum replaced only by lower result
// - writing 0FFFh restarts minimum tracking
// - minimum at pointer 06h, resets 0FFFh
// - maximum replaced only by higher result
// - writing zero restarts maximum tracking
// - maximum at pointer 07h, resets zero
// - unused upper bits read zero; low bits read zero except in the minimum reset value 0FFFh
// - auto mode updates peaks every conversion
// - same protocol at all three rates
// - lines only pulled low or released
// - matching address is acknowledged
// - other addresses left unacknowledged
// - every received write byte acknowledged
// - start condition begins address reception
// - repeated start decodes address afresh
// - speed mode survives repeated start
// - stop condition ends the transaction
// - after stop ignore bus until start
// - nonzero cycle time enables auto mode
// - first write byte sets register pointer
// - master code is never acknowledged
module pktr_top
    import pktr_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_link,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output var  logic        sda_o,
    output var  logic        sda_oe_n,
    input  wire logic        conv_valid,
    input  wire logic [9:0]  conv_result,
    input  wire logic [2:0]  cycle_time,
    output var  logic        auto_mode,
    output var  logic        hs_mode,
    output var  logic [15:0] running_minimum,
    output var  logic [15:0] running_maximum
);

    // ------------------------------------------------------------
    // link domain reset and line synchronisers
    // ------------------------------------------------------------
    logic        rst_link_n;
    logic [1:0]  line_sync;
    wire  [1:0]  line_filt;
    logic [1:0]  line_prev;

    pktr_sync #(.WIDTH(1)) u_rst_sync (
        .clk      (clk_link),
        .async_in (rst_n),
        .sync_out (rst_link_n)
    );

    pktr_sync #(.WIDTH(2)) u_line_sync (
        .clk      (clk_link),
        .async_in ({scl_i, sda_i}),
        .sync_out (line_sync)
    );

    // ------------------------------------------------------------
    // glitch filter: a level must hold FILT_CYC+1 samples
    // ------------------------------------------------------------
    // costs a few link cycles of delay, well inside a bit time at 3.4 MHz
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            logic [FILT_CYC-1:0] hist;
            logic                filt_q;
            wire                 all_high = (&hist) & line_sync[gi];
            wire                 all_low  = ~(|hist) & ~line_sync[gi];

            // one process per bit register, the shared vector is a net
            assign line_filt[gi] = filt_q;

            always_ff @(posedge clk_link) begin
                if (!rst_link_n) begin
                    hist   <= '1;
                    filt_q <= 1'b1;
                end else begin
                    hist   <= {hist[FILT_CYC-2:0], line_sync[gi]};
                    filt_q <= all_high ? 1'b1 : (all_low ? 1'b0 : filt_q);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_link) begin
        if (!rst_link_n) begin
            line_prev <= 2'h3;
        end else begin
            line_prev <= line_filt;
        end
    end

    wire scl_f    = line_filt[1];
    wire sda_f    = line_filt[0];
    wire scl_q    = line_prev[1];
    wire sda_q    = line_prev[0];
    wire scl_rise = scl_f & ~scl_q;
    wire scl_fall = ~scl_f & scl_q;
    wire bus_start = scl_f & scl_q & sda_q & ~sda_f;
    wire bus_stop  = scl_f & scl_q & ~sda_q & sda_f;

    // ------------------------------------------------------------
    // link domain state
    // ------------------------------------------------------------
    pktr_state_t state;
    pktr_state_t next_state;
    logic [3:0]  bitcnt;
    logic [3:0]  next_bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  next_shreg;
    logic [7:0]  ptr;
    logic [7:0]  next_ptr;
    logic [7:0]  upper;
    logic [7:0]  next_upper;
    logic [1:0]  byte_no;
    logic [1:0]  next_byte_no;
    logic        rw;
    logic        next_rw;
    logic        tx_lo;
    logic        next_tx_lo;
    logic        next_oe_n;
    logic        next_hs;
    logic        wr_tog;
    logic        next_wr_tog;
    pktr_wr_t    wr_hold;
    pktr_wr_t    next_wr_hold;
    pktr_peak_t  peak_link;
    logic        snap_seen;

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    wire         sel_min  = (ptr == PTR_RUNNING_MINIMUM);
    wire         sel_max  = (ptr == PTR_RUNNING_MAXIMUM);
    wire  [15:0] rd_word  = sel_min ? peak_link.minimum :
                            sel_max ? peak_link.maximum : READ_UNMAPPED;
    wire  [7:0]  tx_byte  = tx_lo ? rd_word[7:0] : rd_word[15:8];
    wire         addr_hit = (shreg[7:1] == SLAVE_ADDR);
    wire         hs_code  = (shreg[7:3] == HS_MASTER_CODE);

    // ------------------------------------------------------------
    // protocol state machine, sampled on scl rise, driven on scl fall
    // ------------------------------------------------------------
    always_comb begin
        next_state   = state;
        next_bitcnt  = bitcnt;
        next_shreg   = shreg;
        next_ptr     = ptr;
        next_upper   = upper;
        next_byte_no = byte_no;
        next_rw      = rw;
        next_tx_lo   = tx_lo;
        next_oe_n    = sda_oe_n;
        next_hs      = hs_mode;
        next_wr_tog  = wr_tog;
        next_wr_hold = wr_hold;
        if (bus_stop) begin
            next_state = PKTR_IDLE;
            next_oe_n  = 1'b1;
            next_hs    = 1'b0;
        end else if (bus_start) begin
            next_state  = PKTR_ADDR;
            next_bitcnt = '0;
            next_oe_n   = 1'b1;
        end else begin
            case (state)
                PKTR_ADDR, PKTR_RX: begin
                    if (scl_rise) begin
                        next_shreg  = {shreg[6:0], sda_f};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == BYTE_BITS) begin
                        next_bitcnt = '0;
                        if (state == PKTR_ADDR) begin
                            if (addr_hit) begin
                                next_oe_n    = 1'b0;
                                next_rw      = shreg[0];
                                next_byte_no = BYTE_POINTER;
                                next_tx_lo   = 1'b0;
                                next_state   = PKTR_ADDR_ACK;
                            end else begin
                                if (hs_code) begin
                                    next_hs = 1'b1;
                                end
                                next_state = PKTR_IDLE;
                            end
                        end else begin
                            next_oe_n  = 1'b0;
                            next_state = PKTR_RX_ACK;
                            if (byte_no == BYTE_POINTER) begin
                                next_ptr     = shreg;
                                next_byte_no = BYTE_UPPER;
                            end else if (byte_no == BYTE_UPPER) begin
                                next_upper   = shreg;
                                next_byte_no = BYTE_LOWER;
                            end else begin
                                next_wr_hold = '{ptr: ptr, data: {upper, shreg}};
                                next_wr_tog  = ~wr_tog;
                                next_byte_no = BYTE_UPPER;
                            end
                        end
                    end
                end
                PKTR_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_bitcnt = '0;
                        if (rw) begin
                            next_shreg = tx_byte;
                            next_oe_n  = tx_byte[7];
                            next_state = PKTR_TX;
                        end else begin
                            next_oe_n  = 1'b1;
                            next_state = PKTR_RX;
                        end
                    end
                end
                PKTR_RX_ACK: begin
                    if (scl_fall) begin
                        next_oe_n  = 1'b1;
                        next_state = PKTR_RX;
                    end
                end
                PKTR_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == LAST_TX_BIT) begin
                            next_oe_n  = 1'b1;
                            next_tx_lo = ~tx_lo;
                            next_state = PKTR_TX_ACK;
                        end else begin
                            next_shreg  = {shreg[6:0], 1'b0};
                            next_oe_n   = shreg[6];
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                PKTR_TX_ACK: begin
                    if (scl_rise && sda_f) begin
                        next_state = PKTR_IDLE;
                    end else if (scl_fall) begin
                        next_shreg  = tx_byte;
                        next_oe_n   = tx_byte[7];
                        next_bitcnt = '0;
                        next_state  = PKTR_TX;
                    end
                end
                default: begin
                    next_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_link) begin
        if (!rst_link_n) begin
            state    <= PKTR_IDLE;
            bitcnt   <= '0;
            shreg    <= '0;
            ptr      <= '0;
            upper    <= '0;
            byte_no  <= BYTE_POINTER;
            rw       <= 1'b0;
            tx_lo    <= 1'b0;
            sda_oe_n <= 1'b1;
            hs_mode  <= 1'b0;
            wr_tog   <= 1'b0;
            wr_hold  <= '0;
        end else begin
            state    <= next_state;
            bitcnt   <= next_bitcnt;
            shreg    <= next_shreg;
            ptr      <= next_ptr;
            upper    <= next_upper;
            byte_no  <= next_byte_no;
            rw       <= next_rw;
            tx_lo    <= next_tx_lo;
            sda_oe_n <= next_oe_n;
            hs_mode  <= next_hs;
            wr_tog   <= next_wr_tog;
            wr_hold  <= next_wr_hold;
        end
    end

    always_ff @(posedge clk_link) begin
        sda_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // peak snapshot into the link domain
    // ------------------------------------------------------------
    logic        snap_tog;
    logic        snap_tog_link;
    logic        snap_ack_sys;
    pktr_peak_t  snap;

    pktr_sync #(.WIDTH(1)) u_snap_sync (
        .clk      (clk_link),
        .async_in (snap_tog),
        .sync_out (snap_tog_link)
    );

    // snap is held stable by the sys side until the toggle is returned
    always_ff @(posedge clk_link) begin
        if (!rst_link_n) begin
            snap_seen <= 1'b0;
            peak_link <= '{minimum: RST_RUNNING_MINIMUM, maximum: RST_RUNNING_MAXIMUM};
        end else if (snap_tog_link != snap_seen) begin
            snap_seen <= snap_tog_link;
            peak_link <= snap;
        end
    end

    pktr_sync #(.WIDTH(1)) u_ack_sync (
        .clk      (clk_sys),
        .async_in (snap_seen),
        .sync_out (snap_ack_sys)
    );

    // ------------------------------------------------------------
    // register writes into the system domain
    // ------------------------------------------------------------
    logic        wr_tog_sys;
    logic        wr_seen;

    pktr_sync #(.WIDTH(1)) u_wr_sync (
        .clk      (clk_sys),
        .async_in (wr_tog),
        .sync_out (wr_tog_sys)
    );

    // wr_hold is stable: the next write is at least nine scl periods away
    wire         wr_fire   = (wr_tog_sys != wr_seen);
    wire  [15:0] wr_data   = wr_hold.data & PEAK_FIELD_MASK;
    wire         wr_min    = wr_fire & (wr_hold.ptr == PTR_RUNNING_MINIMUM);
    wire         wr_max    = wr_fire & (wr_hold.ptr == PTR_RUNNING_MAXIMUM);

    // ------------------------------------------------------------
    // peak tracking
    // ------------------------------------------------------------
    wire  [15:0] conv_word = {4'h0, conv_result, 2'h0};
    wire         is_lower  = conv_valid & (conv_word < running_minimum);
    wire         is_higher = conv_valid & (conv_word > running_maximum);
    // written baseline masked with PEAK_FIELD_MASK; write wins
    wire  [15:0] next_min  = wr_min ? wr_data : (is_lower ? conv_word : running_minimum);
    // written baseline masked with PEAK_FIELD_MASK; write wins
    wire  [15:0] next_max  = wr_max ? wr_data : (is_higher ? conv_word : running_maximum);
    wire         snap_free = (snap_ack_sys == snap_tog);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            running_minimum <= RST_RUNNING_MINIMUM;
            running_maximum <= RST_RUNNING_MAXIMUM;
            wr_seen         <= 1'b0;
        end else begin
            running_minimum <= next_min;
            running_maximum <= next_max;
            wr_seen         <= wr_tog_sys;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            snap_tog <= 1'b0;
            snap     <= '{minimum: RST_RUNNING_MINIMUM, maximum: RST_RUNNING_MAXIMUM};
        end else if (snap_free) begin
            snap_tog <= ~snap_tog;
            snap     <= '{minimum: running_minimum, maximum: running_maximum};
        end
    end

    // ------------------------------------------------------------
    // automatic conversion mode status
    // ------------------------------------------------------------
    // nonzero cycle time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            auto_mode <= 1'b0;
        end else begin
            auto_mode <= (cycle_time != 3'h0);
        end
    end

endmodule // pktr_top

`default_nettype wire

// *** pktr_master.sv ***
// behavioural two-wire bus master that owns the serial clock
`timescale 1ns/1ps
`default_nettype none

module pktr_master #(
    parameter int Q = 130
) (
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    // ------------------------------------------------------------
    // bus conditions, quarter bit Q keeps 8 link cycles of margin
    // ------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic start();
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #(2*Q);
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask

    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack_in, ack);
    endtask

    task automatic spike();
        scl = 1'b1;
        #20 scl = 1'b0;
    endtask
endmodule // pktr_master

`default_nettype wire

// *** pktr_top_sva.sv ***
// concurrent checks on the peak tracking serial slave ports
`timescale 1ns/1ps
`default_nettype none

module pktr_top_sva
    import pktr_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        clk_link,
    input wire logic        scl_i,
    input wire logic        sda_oe_n,
    input wire logic        conv_valid,
    input wire logic [9:0]  conv_result,
    input wire logic [2:0]  cycle_time,
    input wire logic        auto_mode,
    input wire logic        hs_mode,
    input wire logic [15:0] running_minimum,
    input wire logic [15:0] running_maximum
);
    // ------------------------------------------------------------
    // peak registers
    // ------------------------------------------------------------
    wire logic [15:0] conv_word = {4'h0, conv_result, 2'h0};

    min_reset_a: assert property (@(posedge clk_sys)
        !rst_n |=> running_minimum == RST_RUNNING_MINIMUM) else $error("minimum reset wrong");
    max_reset_a: assert property (@(posedge clk_sys)
        !rst_n |=> running_maximum == RST_RUNNING_MAXIMUM) else $error("maximum reset wrong");
    min_lower_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        conv_valid && conv_word < running_minimum |=> running_minimum == $past(conv_word))
        else $error("minimum not replaced");
    min_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        conv_valid && conv_word >= running_minimum |=> $stable(running_minimum))
        else $error("minimum changed");
    max_higher_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        conv_valid && conv_word > running_maximum |=> running_maximum == $past(conv_word))
        else $error("maximum not replaced");
    max_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        conv_valid && conv_word <= running_maximum |=> $stable(running_maximum))
        else $error("maximum changed");
    auto_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> auto_mode == ($past(cycle_time) != 3'h0)) else $error("auto mode wrong");

    // ------------------------------------------------------------
    // link side, driven bits last far longer than 8 link cycles
    // ------------------------------------------------------------
    ack_hold_a: assert property (@(posedge clk_link) disable iff (!rst_n)
        $fell(sda_oe_n) |=> !sda_oe_n [*8]) else $error("drive too short");
    hs_stop_a: assert property (@(posedge clk_link) disable iff (!rst_n)
        $fell(hs_mode) |-> scl_i) else $error("speed mode left without stop");

    cover property (@(posedge clk_link) $rose(hs_mode));
    cover property (@(posedge clk_link) $fell(sda_oe_n));
    cover property (@(posedge clk_sys) conv_valid && conv_word < running_minimum);
endmodule // pktr_top_sva

bind pktr_top pktr_top_sva chk_u (.clk_sys, .rst_n, .clk_link, .scl_i, .sda_oe_n,
    .conv_valid, .conv_result, .cycle_time, .auto_mode, .hs_mode,
    .running_minimum, .running_maximum);

`default_nettype wire

// *** pktr_top_tb.sv ***
// self-checking bench for the peak tracking serial slave
`timescale 1ns/1ps
`default_nettype none

module pktr_top_tb
    import pktr_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        clk_link = 1'b0;
    logic        rst_n = 1'b0;
    logic        conv_valid = 1'b0;
    logic [9:0]  conv_result = 10'h000;
    logic [2:0]  cycle_time = 3'h0;
    logic        scl, m_low, sda_o, sda_oe_n, auto_mode, hs_mode, k;
    logic [15:0] running_minimum, running_maximum, exp_min, exp_max;
    logic [7:0]  q, u, l;
    int          n_errors = 0;
    int          checks_done = 0;
    // wire-and of both parties with the pull-up
    wire logic   sda = !(m_low || (!sda_oe_n && !sda_o));
    localparam logic [9:0] CONV_TAB [6] = '{10'h200, 10'h300, 10'h100, 10'h200, 10'h300, 10'h3FF};

    always #2.5 clk_sys = ~clk_sys;
    // odd offset keeps the link edges clear of the system edges
    initial begin
        #1.3;
        forever #7.5 clk_link = ~clk_link;
    end

    pktr_top dut_u (.clk_sys, .rst_n, .clk_link, .scl_i(scl), .sda_i(sda), .sda_o,
        .sda_oe_n, .conv_valid, .conv_result, .cycle_time, .auto_mode, .hs_mode,
        .running_minimum, .running_maximum);
    pktr_master m_u (.sda(sda), .scl(scl), .sda_low(m_low));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic hs);
        m_u.start();
        if (hs) begin
            m_u.xfer(8'h09, 1'b1, q, k);
            check("master code ack", k, 1'b1);
            m_u.start();
        end
        m_u.spike();
        m_u.xfer({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, q, k);
        check("address ack", k, 1'b0);
        m_u.xfer(p, 1'b1, q, k);
        check("pointer ack", k, 1'b0);
        m_u.xfer(d[15:8], 1'b1, q, k);
        check("upper ack", k, 1'b0);
        m_u.xfer(d[7:0], 1'b1, q, k);
        check("lower ack", k, 1'b0);
        check("speed mode", hs_mode, hs);
        m_u.stop();
    endtask

    task automatic rd(input logic [7:0] p, input logic [15:0] e);
        m_u.start();
        m_u.xfer({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, q, k);
        m_u.xfer(p, 1'b1, q, k);
        m_u.start();
        m_u.xfer({SLAVE_ADDR_DEFAULT, 1'b1}, 1'b1, q, k);
        check("read address ack", k, 1'b0);
        for (int w = 0; w < 2; w++) begin
            m_u.xfer(8'hFF, 1'b0, u, k);
            m_u.xfer(8'hFF, w == 1, l, k);
            check("read word", {u, l}, e);
        end
        #200;
        check("released", sda, 1'b1);
        m_u.stop();
    endtask

    task automatic conv(input logic [9:0] r);
        logic [15:0] v;
        v = {4'h0, r, 2'h0};
        @(negedge clk_sys);
        conv_valid = 1'b1;
        conv_result = r;
        @(negedge clk_sys);
        conv_valid = 1'b0;
        if (v < exp_min) exp_min = v;
        if (v > exp_max) exp_max = v;
        @(negedge clk_sys);
        check("minimum", running_minimum, exp_min);
        check("maximum", running_maximum, exp_max);
    endtask

    // ------------------------------------------------------------
    // sequence: reset is held long enough for the link domain too
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        #200;
        check("minimum reset", running_minimum, RST_RUNNING_MINIMUM);
        check("maximum reset", running_maximum, RST_RUNNING_MAXIMUM);
        rd(PTR_RUNNING_MINIMUM, RST_RUNNING_MINIMUM);
        rd(PTR_RUNNING_MAXIMUM, RST_RUNNING_MAXIMUM);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            cycle_time = 3'(i);
            @(negedge clk_sys);
            @(negedge clk_sys);
            check("auto mode", auto_mode, i != 0);
        end
        exp_min = RST_RUNNING_MINIMUM;
        exp_max = RST_RUNNING_MAXIMUM;
        foreach (CONV_TAB[i]) conv(CONV_TAB[i]);
        wr(PTR_RUNNING_MINIMUM, 16'h0FFF, 1'b0);
        exp_min = 16'h0FFF & PEAK_FIELD_MASK;
        check("minimum restart", running_minimum, exp_min);
        rd(PTR_RUNNING_MINIMUM, exp_min);
        conv(10'h3FF);
        conv(10'h3FE);
        wr(PTR_RUNNING_MAXIMUM, 16'h0000, 1'b1);
        #200;
        check("speed mode after stop", hs_mode, 1'b0);
        exp_max = 16'h0000;
        conv(10'h001);
        wr(8'h05, 16'h0123, 1'b0);
        rd(8'h05, READ_UNMAPPED);
        m_u.start();
        m_u.xfer({7'h55, 1'b0}, 1'b1, q, k);
        check("foreign address", k, 1'b1);
        m_u.xfer(PTR_RUNNING_MINIMUM, 1'b1, q, k);
        check("after foreign address", k, 1'b1);
        m_u.stop();
        m_u.xfer({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, q, k);
        check("after stop", k, 1'b1);
        m_u.stop();
        close_out();
    end

    initial begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule // pktr_top_tb

`default_nettype wire
